// File: rtl/ifs_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain.
`timescale 1ns/10ps
module ifs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    always_comb begin
        push  = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
        pop   = out_ready_i && (cnt_q != '0);
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        if (push) mem_q[wp_q] <= in_data_i;
    end

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
endmodule

// File: rtl/ifs_slave.sv
// Two-wire serial slave front end of a 128K x 8 memory, sampled on the system clock.
// Assumes SCL/SDA arrive asynchronously; SDA is open drain (oe low = drive SDA_O).
//
// Behaviour
// [RQ1] Master code 00001xxx enters high-speed mode; any STOP leaves it.
// [RQ2] Address is page bit then two bytes, 17 bits, held in a latch.
// [RQ3] Latch increments after each data byte, before the acknowledge slot.
// [RQ4] Latch wraps from top address to zero, reads and writes alike.
// [RQ5] Latch keeps its value; reads start at the current address.
// [RQ6] No limit on bytes per sequential transfer.
// [RQ7] Read drives eight bits, samples ack; ack continues, nack ends.
// [RQ8] All bytes shift most significant bit first.
// [RQ9] Direction bit zero means write; device acks each accepted byte.
// [RQ10] Byte committed after eighth bit; earlier START or STOP aborts it.
// [RQ11] No write delay; device always ready after a write.
// [RQ12] Write protect high: data bytes not acked, latch not incremented.
// [RQ13] Read direction starts shifting out current address data next clock.
// [RQ14] Master ends reads with nack then STOP/START, or STOP/START in slot nine.
// [RQ15] Selective read: address-only write, repeated START, then read address.
// [RQ16] Sleep: F8, own address, restart, 86 all acked; named device sleeps.
// [RQ17] Sleep begins right after acking the command; STOP optional.
// [RQ18] Sleeping device wakes on own address; nacks until recovery time passes.
// [RQ19] Ident: F8, own address, restart, F9; bytes sent until nack.
// [RQ20] Ident word: 12 maker bits, 9 product bits, 3 die revision bits.
// [RQ21] Product field has a serial-number flag bit and a reserved lowest bit.
// [RQ22] Address byte: type code, two select bits, page bit, direction bit.
// [RQ23] START at any time aborts and awaits a new slave address.
// [RQ24] Address latch is zero after reset.
`timescale 1ns/10ps
module ifs_slave
    import ifs_pkg::*;
#(
    parameter int DEPTH = 131072,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESET_I,
    // Serial pins
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_N_O,
    // Strap pins
    input  wire logic [1:0]  DEV_SEL_I,
    input  wire logic        WRITE_PROTECT_I,
    // Status
    output logic             HIGH_SPEED_TRANSFER_MODE_O,
    output logic             SLEEP_O
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_DEVADDR, ST_SELADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_RACK, ST_IGNORE
    } ifs_state_t;

    logic             scl, sda, wp, scl_p_q, sda_p_q;
    logic             scl_rise, scl_fall, start_c, stop_c;
    ifs_state_t       st_q, st_d;
    logic [2:0]       bit_q, bit_d;
    logic [7:0]       sh_q, sh_d;
    logic [16:0]      addr_q, addr_d;
    logic [7:0]       ahi_q, ahi_d;
    logic             ack_slot_q, ack_slot_d;
    logic             ack_drv_q, ack_drv_d;
    logic             sda_o_q, sda_o_d;
    logic             hs_q, hs_d;
    logic             sel_q, sel_d;
    logic             ident_q, ident_d;
    logic [1:0]       idb_q, idb_d;
    logic             sleep_q, sleep_d;
    logic             waking_q, waking_d;
    logic [15:0]      wcnt_q, wcnt_d;
    logic             wr_fire, rd_load;
    logic [7:0]       fifo_dout;
    logic             fifo_vld, fifo_rdy;
    logic [7:0]       mem_q [DEPTH];
    logic [7:0]       rd_byte;
    logic [23:0]      id_word;
    logic [16:0]      wq_addr;
    logic [1:0]       dev_sel;
    logic             sda_oe_n_q;

    ifs_sync u_scl (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .pin_i(SCL_I), .lvl_o(scl));
    ifs_sync u_sda (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .pin_i(SDA_I), .lvl_o(sda));
    ifs_sync u_wp  (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .pin_i(WRITE_PROTECT_I), .lvl_o(wp));
    // Select straps are pins too
    for (genvar g = 0; g < 2; g++) begin : g_sel
        ifs_sync u_sel (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .pin_i(DEV_SEL_I[g]), .lvl_o(dev_sel[g]));
    end

    // Write bytes queue into the array through the FIFO
    ifs_fifo #(.WIDTH(ADDR_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_wq (
        .clk_i      (CLK_SYS_I),
        .rst_i      (RESET_I),
        .in_valid_i (wr_fire),
        .in_ready_o (fifo_rdy),
        .in_data_i  ({addr_q, sh_d}),
        .out_valid_o(fifo_vld),
        .out_ready_i(1'b1),
        .out_data_o ({wq_addr, fifo_dout})
    );

    assign id_word  = {ID_MAKER, ID_DENSITY, ID_SERIAL_FLAG, ID_VARIANT, ID_RESERVED, ID_DIE_REV}; // RQ20 RQ21
    assign rd_byte  = ident_q ? id_word[(5'(ID_BYTE_LAST - idb_q) * 5'h8) +: 8] : mem_q[addr_q]; // RQ13

    always_comb begin
        scl_rise = scl && !scl_p_q;
        scl_fall = !scl && scl_p_q;
        start_c  = scl && scl_p_q && sda_p_q && !sda; // RQ23
        stop_c   = scl && scl_p_q && !sda_p_q && sda;
    end

    always_comb begin
        st_d       = st_q;
        bit_d      = bit_q;
        sh_d       = sh_q;
        addr_d     = addr_q;
        ahi_d      = ahi_q;
        ack_slot_d = ack_slot_q;
        ack_drv_d  = ack_drv_q;
        sda_o_d    = sda_o_q;
        hs_d       = hs_q;
        sel_d      = sel_q;
        ident_d    = ident_q;
        idb_d      = idb_q;
        sleep_d    = sleep_q;
        waking_d   = waking_q;
        wcnt_d     = wcnt_q;
        wr_fire    = 1'b0;
        rd_load    = 1'b0;
        if (waking_q) begin
            wcnt_d = wcnt_q - 16'h1;
            if (wcnt_q == 16'h1) begin
                waking_d = 1'b0; // RQ18
            end
        end
        if (start_c) begin
            st_d = ST_DEVADDR; // RQ23 RQ15
            bit_d = '0;
            // First SCL fall after START carries no bit
            ack_slot_d = 1'b1;
            ack_drv_d = 1'b0;
            sda_o_d = 1'b1;
            ident_d = 1'b0;
        end else if (stop_c) begin
            st_d = ST_IDLE;
            hs_d = 1'b0; // RQ1
            sel_d = 1'b0;
            ack_slot_d = 1'b0;
            ack_drv_d = 1'b0;
            sda_o_d = 1'b1;
            ident_d = 1'b0;
        end else if (scl_rise && ack_slot_q) begin
            if (st_q == ST_RACK) begin
                st_d = sda ? ST_IDLE : ST_RDATA; // RQ7
            end
        end else if (scl_fall && ack_slot_q) begin
            ack_slot_d = 1'b0;
            ack_drv_d = 1'b0;
            sda_o_d = 1'b1;
            if (st_q == ST_RDATA) begin
                rd_load = 1'b1;
                sda_o_d = rd_byte[BIT_LAST]; // RQ8
                ack_drv_d = 1'b1;
                sh_d = rd_byte;
            end
        end else if (scl_rise && st_q != ST_IDLE && st_q != ST_IGNORE && st_q != ST_RDATA) begin
            sh_d = {sh_q[6:0], sda}; // RQ8
            bit_d = bit_q + 3'h1;
        end else if (scl_fall && st_q == ST_RDATA) begin
            if (bit_q == BIT_LAST) begin
                bit_d = '0;
                ack_slot_d = 1'b1;
                ack_drv_d = 1'b0;
                sda_o_d = 1'b1;
                st_d = ST_RACK;
                if (ident_q) begin
                    idb_d = (idb_q == ID_BYTE_LAST) ? 2'h0 : idb_q + 2'h1;
                end else begin
                    addr_d = (addr_q == ADDR_LAST) ? ADDR_RESET : addr_q + 17'h1; // RQ3 RQ4 RQ6
                end
            end else begin
                bit_d = bit_q + 3'h1;
                sda_o_d = sh_q[3'(BIT_LAST - bit_q - 3'h1)]; // RQ8
            end
        end else if (scl_fall && bit_q == '0 && st_q != ST_IDLE && st_q != ST_IGNORE && st_q != ST_RDATA
                     && !ack_slot_q) begin
            // Eighth bit just shifted in; decide on acknowledge
            ack_slot_d = 1'b1;
            ack_drv_d = 1'b0;
            sda_o_d = 1'b1;
            case (st_q)
                ST_DEVADDR: begin
                    if (sh_q[7:3] == HS_CODE_TOP) begin
                        hs_d = 1'b1; // RQ1
                        st_d = ST_IGNORE;
                        ack_slot_d = 1'b0;
                    end else if (sh_q == RSV_ID_SELECT) begin
                        ack_drv_d = !sleep_q && !waking_q;
                        sda_o_d = 1'b0;
                        st_d = ST_SELADDR; // RQ16 RQ19
                    end else if (sel_q && sh_q == CMD_SLEEP) begin
                        ack_drv_d = 1'b1;
                        sda_o_d = 1'b0;
                        sleep_d = 1'b1; // RQ16 RQ17
                        sel_d = 1'b0;
                        st_d = ST_IGNORE;
                    end else if (sel_q && sh_q == RSV_ID_IDENT) begin
                        ack_drv_d = 1'b1;
                        sda_o_d = 1'b0;
                        ident_d = 1'b1; // RQ19
                        idb_d = '0;
                        sel_d = 1'b0;
                        st_d = ST_RDATA;
                    end else if (sh_q[7:4] == DEV_TYPE_CODE && sh_q[3:2] == dev_sel) begin // RQ22
                        sel_d = 1'b0;
                        if (sleep_q) begin
                            sleep_d = 1'b0;
                            waking_d = 1'b1;
                            wcnt_d = WAKE_REC_CNT;
                            st_d = ST_IGNORE; // RQ18
                        end else if (waking_q) begin
                            st_d = ST_IGNORE; // RQ18
                        end else begin
                            ack_drv_d = 1'b1; // RQ11
                            sda_o_d = 1'b0;
                            addr_d[16] = sh_q[1] ? 1'b1 : (sh_q[0] ? addr_q[16] : 1'b0); // RQ2
                            if (sh_q[0]) begin
                                addr_d = addr_q; // RQ5 RQ13
                                st_d = ST_RDATA;
                            end else begin
                                st_d = ST_ADDR_HI; // RQ9
                            end
                        end
                    end else begin
                        st_d = ST_IGNORE;
                        ack_slot_d = 1'b0;
                    end
                end
                ST_SELADDR: begin
                    if (sh_q[7:4] == DEV_TYPE_CODE && sh_q[3:2] == dev_sel) begin
                        ack_drv_d = 1'b1;
                        sda_o_d = 1'b0;
                        sel_d = 1'b1;
                    end
                    st_d = ST_IGNORE;
                end
                ST_ADDR_HI: begin
                    ack_drv_d = 1'b1;
                    sda_o_d = 1'b0;
                    ahi_d = sh_q;
                    st_d = ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    ack_drv_d = 1'b1;
                    sda_o_d = 1'b0;
                    addr_d = {addr_q[16], ahi_q, sh_q}; // RQ2 RQ15
                    st_d = ST_WDATA;
                end
                ST_WDATA: begin
                    if (!wp && fifo_rdy) begin // RQ12
                        wr_fire = 1'b1; // RQ10
                        ack_drv_d = 1'b1;
                        sda_o_d = 1'b0;
                        addr_d = (addr_q == ADDR_LAST) ? ADDR_RESET : addr_q + 17'h1; // RQ3 RQ4
                    end else begin
                        st_d = ST_IGNORE;
                    end
                end
                default: st_d = ST_IGNORE;
            endcase
        end
    end

    // Commit byte lands in the array ahead of any following read
    always_ff @(posedge CLK_SYS_I) begin
        if (fifo_vld) begin
            mem_q[wq_addr] <= fifo_dout; // RQ10
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            st_q       <= ST_IDLE;
            bit_q      <= '0;
            sh_q       <= '0;
            addr_q     <= ADDR_RESET; // RQ24
            ahi_q      <= '0;
            ack_slot_q <= 1'b0;
            ack_drv_q  <= 1'b0;
            sda_oe_n_q <= 1'b1;
            sda_o_q    <= 1'b1;
            hs_q       <= 1'b0;
            sel_q      <= 1'b0;
            ident_q    <= 1'b0;
            idb_q      <= '0;
            sleep_q    <= 1'b0;
            waking_q   <= 1'b0;
            wcnt_q     <= '0;
        end else begin
            scl_p_q    <= scl;
            sda_p_q    <= sda;
            st_q       <= st_d;
            bit_q      <= bit_d;
            sh_q       <= sh_d;
            addr_q     <= addr_d;
            ahi_q      <= ahi_d;
            ack_slot_q <= ack_slot_d;
            ack_drv_q  <= ack_drv_d;
            sda_oe_n_q <= !ack_drv_d;
            sda_o_q    <= sda_o_d;
            hs_q       <= hs_d;
            sel_q      <= sel_d;
            ident_q    <= ident_d;
            idb_q      <= idb_d;
            sleep_q    <= sleep_d;
            waking_q   <= waking_d;
            wcnt_q     <= wcnt_d;
        end
    end

    assign SDA_O                      = sda_o_q;
    assign SDA_OE_N_O                 = sda_oe_n_q;
    assign HIGH_SPEED_TRANSFER_MODE_O = hs_q;
    assign SLEEP_O                    = sleep_q;

    AST_STOP_EXITS_HS: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ1
        stop_c |=> !hs_q) else $error("High-speed mode kept after STOP");
    AST_WRAP: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ4
        wr_fire && addr_q == ADDR_LAST |=> addr_q == ADDR_RESET) else $error("Latch did not wrap");
    AST_WP_NOACK: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ12
        wp |-> !wr_fire) else $error("Write taken while protected");
    AST_START_ABORT: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ23
        start_c |=> st_q == ST_DEVADDR && SDA_OE_N_O) else $error("START did not abort");
    AST_WAKE_NACK: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ18
        waking_q |-> !wr_fire) else $error("Write while waking");
    AST_WR_INC: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ3
        wr_fire && addr_q != ADDR_LAST |=> addr_q == $past(addr_q) + 17'h1) else $error("No increment");
    AST_SLEEP_RELEASE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ17
        $rose(sleep_q) |-> st_q == ST_IGNORE) else $error("Sleep without idle");
    AST_RACK_NACK: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ7
        scl_rise && ack_slot_q && st_q == ST_RACK && sda && !start_c && !stop_c |=> st_q == ST_IDLE)
        else $error("Read not ended on nack");

    // Read byte loaded after the ack slot, its top bit driven next cycle
    sequence seq_rd_load;
        rd_load;
    endsequence
    AST_RD_FIRST_BIT: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RQ13
        seq_rd_load |=> !SDA_OE_N_O && SDA_O == $past(rd_byte[BIT_LAST])) else $error("Read bit not driven");
endmodule

// File: rtl/ifs_sync.sv
// Three-stage pin synchroniser; output changes when stages two and three agree.
// Assumes the input is asynchronous to the clock.
`timescale 1ns/10ps
module ifs_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin
    input  wire logic pin_i,
    output logic      lvl_o
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic       lvl_q;
    logic       lvl_d;

    always_comb begin
        sh_d  = {sh_q[1:0], pin_i};
        lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_q  <= 3'h7;
            lvl_q <= 1'b1;
        end else begin
            sh_q  <= sh_d;
            lvl_q <= lvl_d;
        end
    end

    assign lvl_o = lvl_q;
endmodule

// File: shared/ifs_pkg.sv
// Package for the two-wire memory slave: protocol codes, field layouts, timing.
// Assumes a 20 MHz system clock sampling the serial pins.
package ifs_pkg;
    localparam int          ADDR_W         = 17;
    localparam int          DATA_W         = 8;
    localparam logic [3:0]  DEV_TYPE_CODE  = 4'ha;
    localparam logic [7:0]  RSV_ID_SELECT  = 8'hf8;
    localparam logic [7:0]  RSV_ID_IDENT   = 8'hf9;
    localparam logic [7:0]  CMD_SLEEP      = 8'h86;
    localparam logic [4:0]  HS_CODE_TOP    = 5'h01;
    localparam logic [16:0] ADDR_RESET     = 17'h00000;
    localparam logic [16:0] ADDR_LAST      = 17'h1ffff;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [1:0]  ID_BYTE_LAST   = 2'h2;
    // Identification word fields (values arbitrary)
    localparam logic [11:0] ID_MAKER       = 12'h5a5;
    localparam logic [3:0]  ID_DENSITY     = 4'h3;
    localparam logic        ID_SERIAL_FLAG = 1'b0;
    localparam logic [2:0]  ID_VARIANT     = 3'h0;
    localparam logic        ID_RESERVED    = 1'b0;
    localparam logic [2:0]  ID_DIE_REV     = 3'h0;
    // Wake recovery time in ns and its cycle count at 20 MHz
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          WAKE_REC_NS    = 400;
    localparam int          WAKE_REC_CYC   = (WAKE_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] WAKE_REC_CNT   = 16'(WAKE_REC_CYC);
endpackage

// File: test/ifs_master_model.sv
// Two-wire bus master model: frames, bytes and acks on an open-drain pair.
// Assumes a pulled-up SDA wire; all moves are paced by the system clock's falling edge.
`timescale 1ns/10ps
module ifs_master_model (
    // Pacing clock
    input  wire logic clk_i,
    // Bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // One bit slot, 400 ns: SCL low 300 ns to cover the slave's answer delay, high 100 ns
    task automatic bit_io(input logic b, output logic s);
        wt(1);
        sda_o = b;
        wt(5);
        scl_o = 1'b1;
        wt(1);
        s = sda_i;
        wt(1);
        scl_o = 1'b0;
    endtask

    // Start or repeated start, once the slave has let SDA go
    task automatic start();
        wt(6);
        sda_o = 1'b1;
        wt(2);
        scl_o = 1'b1;
        wt(2);
        sda_o = 1'b0;
        wt(2);
        scl_o = 1'b0;
    endtask

    // Stop, bus left idle and clock still
    task automatic stop();
        wt(2);
        sda_o = 1'b0;
        wt(2);
        scl_o = 1'b1;
        wt(2);
        sda_o = 1'b1;
        wt(2);
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask

    // Nack on the last byte ends a read
    task automatic recv(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule

// File: test/ifs_slave_tb.sv
// Bench for the two-wire memory slave: master model plus byte-level reference model.
// Assumes the package, the design files and the master model compile first.
`timescale 1ns/10ps
module ifs_slave_tb;
    import ifs_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wp = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic        scl;
    logic        m_sda;
    logic        sda_o;
    logic        sda_oe_n;
    logic        hs;
    logic        slp;
    wire         sda;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          addr = 0;
    logic [7:0]  mem [int];
    logic        a;
    logic [7:0]  b;
    logic [23:0] id;

    // Open-drain wire with pull-up
    assign sda = m_sda & (sda_oe_n | sda_o);

    always #25 clk = ~clk;

    ifs_slave dut (.CLK_SYS_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_N_O(sda_oe_n), .DEV_SEL_I(sel), .WRITE_PROTECT_I(wp),
        .HIGH_SPEED_TRANSFER_MODE_O(hs), .SLEEP_O(slp));
    ifs_master_model m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tx(input logic [7:0] d, input logic e);
        m.send(d, a);
        chk("ack", 24'(a), 24'(e));
    endtask

    task automatic hdr(input int ad, input logic rw);
        m.start();
        tx({DEV_TYPE_CODE, sel, ad[16], rw}, 1'b0);
    endtask

    // Address write then n random data bytes, no stop
    task automatic wr(input int ad, input int n);
        hdr(ad, 1'b0);
        tx(ad[15:8], 1'b0);
        tx(ad[7:0], 1'b0);
        addr = ad;
        repeat (n) begin
            b = 8'($urandom);
            tx(b, wp);
            if (!wp) begin
                mem[addr] = b;
                addr = (addr + 1) % 131072;
            end
        end
    endtask

    // Current address read of n bytes, nack on the last
    task automatic rd(input int n);
        hdr(addr, 1'b1);
        for (int i = 1; i <= n; i++) begin
            m.recv(b, i == n);
            chk("data", 24'(b), 24'(mem[addr]));
            addr = (addr + 1) % 131072;
        end
        m.stop();
    endtask

    task automatic sel_seq(input logic [7:0] cmd);
        m.start();
        tx(RSV_ID_SELECT, 1'b0);
        tx({DEV_TYPE_CODE, sel, 2'($urandom)}, 1'b0);
        m.start();
        tx(cmd, 1'b0);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(71607));
        sel = 2'($urandom);
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        // Wrapping write, then selective and current reads
        wr(131070, 4);
        m.stop();
        wr(131070, 0);
        rd(3);
        rd(1);
        // Other select straps
        m.start();
        tx({DEV_TYPE_CODE, ~sel, 2'b00}, 1'b1);
        m.stop();
        // Protected write, then aborted byte
        wr(65536, 1);
        m.stop();
        wp = 1'b1;
        wr(65536, 2);
        m.stop();
        wp = 1'b0;
        wr(65536, 0);
        repeat (4) m.bit_io(1'b0, a);
        m.stop();
        rd(1);
        // High-speed master code
        m.start();
        m.send({HS_CODE_TOP, 3'($urandom)}, a);
        chk("hs", 24'(hs), 24'h1);
        m.stop();
        m.wt(4);
        chk("hs", 24'(hs), 24'h0);
        // Identification word
        sel_seq(RSV_ID_IDENT);
        for (int i = 2; i >= 0; i--) m.recv(id[i*8 +: 8], i == 0);
        chk("ident", id, {ID_MAKER, ID_DENSITY, ID_SERIAL_FLAG, ID_VARIANT, ID_RESERVED, ID_DIE_REV});
        m.stop();
        // Sleep, no stop, then wake by own address
        sel_seq(CMD_SLEEP);
        m.wt(6);
        chk("sleep", 24'(slp), 24'h1);
        chk("release", 24'(sda_oe_n), 24'h1);
        m.start();
        m.send({DEV_TYPE_CODE, sel, 2'b00}, a);
        m.stop();
        m.wt(WAKE_REC_CYC + 8);
        wr(5, 1);
        m.stop();
        chk("sleep", 24'(slp), 24'h0);
        // Reset in mid-run: latch back to zero, array kept
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        addr = 0;
        rd(1);
        finish_test();
    end
endmodule
